// [include/osc_pkg.sv]
// Constants, types and register map of the output state configuration bank.
// Assumes a single core clock; the serial port pins are synchronous to it.
package osc_pkg;

  localparam int OSC_NUM_SYNC = 8;
  localparam int OSC_NUM_CLK = 8;
  localparam int OSC_NUM_CHAN = 4;

  typedef logic [6:0] osc_addr_t;
  typedef logic [7:0][7:0] osc_bank_t;
  typedef logic [7:0][1:0] osc_amp_t;
  typedef logic [7:0][9:0] osc_mv_t;
  typedef logic [7:0][2:0] osc_dly_t;
  typedef logic [3:0][7:0] osc_phase_t;

  // Output order: A0, A1, A2, B0, B1, C0, C1, D
  localparam osc_addr_t OSC_SYNC_SRC_ADDR [OSC_NUM_SYNC] =
    '{7'h28, 7'h29, 7'h2a, 7'h38, 7'h39, 7'h48, 7'h49, 7'h58};
  localparam osc_addr_t OSC_SYNC_DRV_ADDR [OSC_NUM_SYNC] =
    '{7'h2c, 7'h2d, 7'h2e, 7'h3c, 7'h3d, 7'h4c, 7'h4d, 7'h5c};
  localparam osc_addr_t OSC_SYNC_ENA_ADDR = 7'h76;
  localparam osc_addr_t OSC_CLK_DRV_BASE = 7'h60;
  localparam osc_addr_t OSC_CLK_PHASE_BASE = 7'h70;
  // Clock output to channel (A=0 .. D=3)
  localparam logic [1:0] OSC_CLK_CHAN [OSC_NUM_CLK] =
    '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};

  // Sync source/delay register fields
  localparam int OSC_SRC_SEL_BIT = 4;
  localparam int OSC_DLY_HI = 3;
  localparam int OSC_DLY_LO = 1;
  // Sync drive register fields; clock drive uses format/amplitude the same way
  localparam int OSC_PD_BIT = 7;
  localparam int OSC_BIAS_BIT = 5;
  localparam int OSC_FMT_BIT = 4;
  localparam int OSC_AMP_HI = 3;
  localparam int OSC_AMP_LO = 2;
  localparam int OSC_CLK_EN_BIT = 0;

  localparam logic [7:0] OSC_SRC_MASK = 8'h1e;
  localparam logic [7:0] OSC_DRV_MASK = 8'hbc;
  localparam logic [7:0] OSC_CLK_DRV_MASK = 8'h1d;
  localparam logic [7:0] OSC_SRC_RST = 8'h10;
  localparam logic [7:0] OSC_DRV_RST = 8'h00;
  localparam logic [7:0] OSC_ENA_RST = 8'h00;
  localparam logic [7:0] OSC_CLK_DRV_RST = 8'h00;
  localparam logic [7:0] OSC_PHASE_RST = 8'h00;

  localparam logic [9:0] OSC_SWING_STEP_MV = 10'h0fa;

  // Register kinds returned by the address decoder
  localparam logic [2:0] OSC_KIND_NONE = 3'h0;
  localparam logic [2:0] OSC_KIND_SRC = 3'h1;
  localparam logic [2:0] OSC_KIND_DRV = 3'h2;
  localparam logic [2:0] OSC_KIND_ENA = 3'h3;
  localparam logic [2:0] OSC_KIND_CDRV = 3'h4;
  localparam logic [2:0] OSC_KIND_PHASE = 3'h5;

  // Serial frame: R/W flag, 7-bit address, 8-bit data, MSB first
  localparam logic [4:0] OSC_CMD_LAST = 5'h07;
  localparam logic [4:0] OSC_FRAME_LAST = 5'h0f;

  typedef enum logic [5:0] {
    OSC_SPI_IDLE = 6'b000001,
    OSC_SPI_CMD = 6'b000010,
    OSC_SPI_WR = 6'b000100,
    OSC_SPI_RDLD = 6'b001000,
    OSC_SPI_RD = 6'b010000,
    OSC_SPI_HOLD = 6'b100000
  } osc_spi_e;

endpackage

// [hdl/osc_spi_slave.sv]
// Three-wire serial slave: 16-bit frames into register strobes.
// Assumes sclk idles low and each sclk phase lasts at least three core clocks.
`timescale 1ns/1ps
`default_nettype none
module osc_spi_slave (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  output osc_pkg::osc_addr_t regAddr,
  output logic [7:0] regWrData,
  output logic regWrStb,
  input wire logic [7:0] regRdData
);
  import osc_pkg::*;

  typedef struct packed {
    osc_spi_e state;
    logic sclkPrev;
    logic [4:0] bitCnt;
    logic [6:0] cmdShift;
    osc_addr_t addr;
    logic [7:0] wrData;
    logic wrStb;
    logic [7:0] rdShift;
  } osc_spi_s;

  osc_spi_s s_r;
  osc_spi_s s_nxt;
  logic rise;

  always_comb begin
    s_nxt = s_r;
    s_nxt.wrStb = 1'b0;
    s_nxt.sclkPrev = spiSclk;
    rise = spiSclk & ~s_r.sclkPrev;
    if (spiCsN) begin
      // Deselect aborts any unfinished frame; no partial write lands
      s_nxt.state = OSC_SPI_IDLE;
      s_nxt.bitCnt = 5'h00;
    end else begin
      case (s_r.state)
        OSC_SPI_IDLE, OSC_SPI_CMD: begin
          s_nxt.state = OSC_SPI_CMD;
          if (rise) begin
            s_nxt.cmdShift = {s_r.cmdShift[5:0], sdioIn};
            s_nxt.bitCnt = s_r.bitCnt + 5'h01;
            if (s_r.bitCnt == OSC_CMD_LAST) begin
              s_nxt.addr = {s_r.cmdShift[5:0], sdioIn};
              s_nxt.state = s_r.cmdShift[6] ? OSC_SPI_RDLD : OSC_SPI_WR;
            end
          end
        end
        OSC_SPI_WR: begin
          if (rise) begin
            s_nxt.wrData = {s_r.wrData[6:0], sdioIn};
            s_nxt.bitCnt = s_r.bitCnt + 5'h01;
            if (s_r.bitCnt == OSC_FRAME_LAST) begin
              s_nxt.wrStb = 1'b1;
              s_nxt.state = OSC_SPI_HOLD;
            end
          end
        end
        OSC_SPI_RDLD: begin
          s_nxt.rdShift = regRdData;
          s_nxt.state = OSC_SPI_RD;
        end
        OSC_SPI_RD: begin
          if (rise) begin
            s_nxt.rdShift = {s_r.rdShift[6:0], 1'b0};
            s_nxt.bitCnt = s_r.bitCnt + 5'h01;
            if (s_r.bitCnt == OSC_FRAME_LAST) begin
              s_nxt.state = OSC_SPI_HOLD;
            end
          end
        end
        OSC_SPI_HOLD: begin
          s_nxt.state = OSC_SPI_HOLD;
        end
        default: begin
          s_nxt.state = OSC_SPI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{state: OSC_SPI_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sdioOut = s_r.rdShift[7];
  assign sdioOe = (s_r.state == OSC_SPI_RD);
  assign regAddr = s_r.addr;
  assign regWrData = s_r.wrData;
  assign regWrStb = s_r.wrStb;

endmodule
`default_nettype wire

// [hdl/osc_output_state_regs.sv]
// Output state configuration bank: clock and sync output settings.
// Assumes a host on the three-wire serial port; drives analog control lines.
`timescale 1ns/1ps
`default_nettype none
module osc_output_state_regs (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  output logic [7:0] clkOutEnable,
  output logic [7:0] clkOutFormat,
  output osc_pkg::osc_amp_t clkOutAmp,
  output osc_pkg::osc_mv_t clkOutSwingMv,
  output osc_pkg::osc_phase_t clkOutPhase,
  output logic [7:0] syncOutPowerDown,
  output logic [7:0] syncOutEnable,
  output logic [7:0] syncOutSourceSel,
  output osc_pkg::osc_dly_t syncOutDelay,
  output logic [7:0] syncOutFormat,
  output osc_pkg::osc_amp_t syncOutAmp,
  output osc_pkg::osc_mv_t syncOutSwingMv,
  output logic [7:0] syncOutBiasDisable
);
  import osc_pkg::*;

  typedef struct packed {
    osc_bank_t src;
    osc_bank_t drv;
    logic [7:0] ena;
    osc_bank_t clkDrv;
    osc_phase_t phase;
    logic [7:0] clkEn;
    logic [7:0] clkFmt;
    osc_amp_t clkAmp;
    osc_mv_t clkMv;
    osc_phase_t clkPh;
    logic [7:0] syPd;
    logic [7:0] syEn;
    logic [7:0] sySrc;
    osc_dly_t syDly;
    logic [7:0] syFmt;
    osc_amp_t syAmp;
    osc_mv_t syMv;
    logic [7:0] syBias;
  } osc_state_s;

  osc_state_s s_r;
  osc_state_s s_nxt;
  logic [1:0] rstSync_r;
  logic rstN;
  osc_addr_t regAddr;
  logic [7:0] regWrData;
  logic regWrStb;
  logic [7:0] regRdData;
  logic [5:0] wrDec;
  logic [5:0] rdDec;

  logic [7:0] effClkEn;
  logic [7:0] effClkFmt;
  osc_amp_t effClkAmp;
  osc_mv_t effClkMv;
  logic [7:0] effSyPd;
  logic [7:0] effSyEn;
  logic [7:0] effSySrc;
  osc_dly_t effSyDly;
  logic [7:0] effSyFmt;
  osc_amp_t effSyAmp;
  osc_mv_t effSyMv;
  logic [7:0] effSyBias;

  // Reset released through two flops so all state leaves reset on one edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];

  osc_spi_slave u_spi (
    .core_clk(core_clk),
    .rst_n(rstN),
    .spiSclk(spiSclk),
    .spiCsN(spiCsN),
    .sdioIn(sdioIn),
    .sdioOut(sdioOut),
    .sdioOe(sdioOe),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStb(regWrStb),
    .regRdData(regRdData)
  );

  // Address to {kind, index}; shared by the write and read paths
  function automatic logic [5:0] regDecode(input osc_addr_t a);
    logic [5:0] d;
    d = {OSC_KIND_NONE, 3'h0};
    for (int i = 0; i < OSC_NUM_SYNC; i++) begin
      if (a == OSC_SYNC_SRC_ADDR[i]) begin
        d = {OSC_KIND_SRC, 3'(i)};
      end
      if (a == OSC_SYNC_DRV_ADDR[i]) begin
        d = {OSC_KIND_DRV, 3'(i)};
      end
    end
    if (a == OSC_SYNC_ENA_ADDR) begin
      d = {OSC_KIND_ENA, 3'h0};
    end
    if (a[6:3] == OSC_CLK_DRV_BASE[6:3]) begin
      d = {OSC_KIND_CDRV, a[2:0]};
    end
    if (a[6:2] == OSC_CLK_PHASE_BASE[6:2]) begin
      d = {OSC_KIND_PHASE, 1'b0, a[1:0]};
    end
    return d;
  endfunction

  assign wrDec = regDecode(regAddr);
  assign rdDec = regDecode(regAddr);

  // Reserved bits are never stored, so they read back as zero
  always_comb begin
    case (rdDec[5:3])
      OSC_KIND_SRC: regRdData = s_r.src[rdDec[2:0]];
      OSC_KIND_DRV: regRdData = s_r.drv[rdDec[2:0]];
      OSC_KIND_ENA: regRdData = s_r.ena;
      OSC_KIND_CDRV: regRdData = s_r.clkDrv[rdDec[2:0]];
      OSC_KIND_PHASE: regRdData = s_r.phase[rdDec[1:0]];
      default: regRdData = 8'h00;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < OSC_NUM_CLK; g++) begin : gen_out
      // Clock outputs
      assign effClkEn[g] = s_r.clkDrv[g][OSC_CLK_EN_BIT];
      assign effClkFmt[g] = s_r.clkDrv[g][OSC_FMT_BIT];
      assign effClkAmp[g] = s_r.clkDrv[g][OSC_AMP_HI:OSC_AMP_LO];
      // Same swing table in both formats
      assign effClkMv[g] = OSC_SWING_STEP_MV * ({8'h00, effClkAmp[g]} + 10'h001);

      // Sync outputs; enable bits run from D7 for output A0 downward
      assign effSyPd[g] = s_r.drv[g][OSC_PD_BIT];
      assign effSySrc[g] = s_r.src[g][OSC_SRC_SEL_BIT];
      assign effSyDly[g] = s_r.src[g][OSC_DLY_HI:OSC_DLY_LO];
      // Powered-down output ignores its format, enable and amplitude
      assign effSyEn[g] = s_r.ena[OSC_NUM_SYNC - 1 - g] & ~effSyPd[g];
      assign effSyFmt[g] = s_r.drv[g][OSC_FMT_BIT] & ~effSyPd[g];
      assign effSyAmp[g] = effSyPd[g] ? 2'h0 : s_r.drv[g][OSC_AMP_HI:OSC_AMP_LO];
      assign effSyMv[g] = effSyPd[g] ? 10'h000 :
        OSC_SWING_STEP_MV * ({8'h00, effSyAmp[g]} + 10'h001);
      // Pre-bias only acts on a powered ECL-style output
      assign effSyBias[g] = s_r.drv[g][OSC_BIAS_BIT] & effSyFmt[g];
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;
    if (regWrStb) begin
      case (wrDec[5:3])
        OSC_KIND_SRC: begin
          s_nxt.src[wrDec[2:0]] = regWrData & OSC_SRC_MASK;
        end
        OSC_KIND_DRV: begin
          s_nxt.drv[wrDec[2:0]] = regWrData & OSC_DRV_MASK;
        end
        OSC_KIND_ENA: begin
          s_nxt.ena = regWrData;
        end
        OSC_KIND_CDRV: begin
          s_nxt.clkDrv[wrDec[2:0]] = regWrData & OSC_CLK_DRV_MASK;
        end
        OSC_KIND_PHASE: begin
          // All-ones is a legal code: 255 input periods
          s_nxt.phase[wrDec[1:0]] = regWrData;
        end
        default: begin
          s_nxt.ena = s_r.ena;
        end
      endcase
    end
    // Output controls follow the stored fields one cycle later
    s_nxt.clkEn = effClkEn;
    s_nxt.clkFmt = effClkFmt;
    s_nxt.clkAmp = effClkAmp;
    s_nxt.clkMv = effClkMv;
    s_nxt.clkPh = s_r.phase;
    s_nxt.syPd = effSyPd;
    s_nxt.syEn = effSyEn;
    s_nxt.sySrc = effSySrc;
    s_nxt.syDly = effSyDly;
    s_nxt.syFmt = effSyFmt;
    s_nxt.syAmp = effSyAmp;
    s_nxt.syMv = effSyMv;
    s_nxt.syBias = effSyBias;
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      s_r <= '{
        src: {OSC_NUM_SYNC{OSC_SRC_RST}},
        drv: {OSC_NUM_SYNC{OSC_DRV_RST}},
        ena: OSC_ENA_RST,
        clkDrv: {OSC_NUM_CLK{OSC_CLK_DRV_RST}},
        phase: {OSC_NUM_CHAN{OSC_PHASE_RST}},
        sySrc: 8'hff,
        syMv: {OSC_NUM_SYNC{OSC_SWING_STEP_MV}},
        clkMv: {OSC_NUM_CLK{OSC_SWING_STEP_MV}},
        default: '0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  assign clkOutEnable = s_r.clkEn;
  assign clkOutFormat = s_r.clkFmt;
  assign clkOutAmp = s_r.clkAmp;
  assign clkOutSwingMv = s_r.clkMv;
  assign clkOutPhase = s_r.clkPh;
  assign syncOutPowerDown = s_r.syPd;
  assign syncOutEnable = s_r.syEn;
  assign syncOutSourceSel = s_r.sySrc;
  assign syncOutDelay = s_r.syDly;
  assign syncOutFormat = s_r.syFmt;
  assign syncOutAmp = s_r.syAmp;
  assign syncOutSwingMv = s_r.syMv;
  assign syncOutBiasDisable = s_r.syBias;

endmodule
`default_nettype wire

// [tb/osc_output_state_regs_props.sv]
// Concurrent checks on the output state configuration bank.
// Assumes binding to the bank top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module osc_output_state_regs_props (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic spiCsN,
  input wire logic sdioOe,
  input wire logic [7:0] clkOutEnable,
  input wire osc_pkg::osc_amp_t clkOutAmp,
  input wire osc_pkg::osc_mv_t clkOutSwingMv,
  input wire osc_pkg::osc_phase_t clkOutPhase,
  input wire logic [7:0] syncOutPowerDown,
  input wire logic [7:0] syncOutEnable,
  input wire logic [7:0] syncOutFormat,
  input wire osc_pkg::osc_amp_t syncOutAmp,
  input wire osc_pkg::osc_mv_t syncOutSwingMv,
  input wire logic [7:0] syncOutBiasDisable
);
  import osc_pkg::*;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  sequence csHeld;
    spiCsN [*4];
  endsequence
  sequence busIdle;
    spiCsN [*6];
  endsequence
  function automatic logic [9:0] swing(logic [1:0] c);
    return ({8'h0, c} + 10'h1) * OSC_SWING_STEP_MV;
  endfunction
  for (genvar i = 0; i < 8; i++) begin : g_out
    AST_SYNC_PD_GATES: assert property (
      syncOutPowerDown[i] |-> !syncOutEnable[i] && !syncOutFormat[i])
      else $error("powered-down sync output still enabled");
    AST_SYNC_PD_AMP: assert property (
      syncOutPowerDown[i] |-> syncOutAmp[i] == 2'h0 && syncOutSwingMv[i] == 10'h0)
      else $error("powered-down sync output keeps amplitude");
    AST_CLK_SWING: assert property (clkOutSwingMv[i] == swing(clkOutAmp[i]))
      else $error("clock output swing does not follow code");
    AST_SYNC_SWING: assert property (
      !syncOutPowerDown[i] |-> syncOutSwingMv[i] == swing(syncOutAmp[i]))
      else $error("sync output swing does not follow code");
    AST_BIAS_NEEDS_ECL: assert property (
      syncOutBiasDisable[i] |-> syncOutFormat[i] && !syncOutPowerDown[i])
      else $error("bias disable active outside powered ECL format");
  end
  AST_OE_IDLE: assert property (csHeld |-> !sdioOe)
    else $error("data pin driven while deselected");
  AST_OE_IN_FRAME: assert property ($rose(sdioOe) |-> !spiCsN && !$past(spiCsN, 8))
    else $error("data pin driven outside a read frame");
  AST_CFG_STABLE: assert property (
    busIdle |-> $stable({syncOutPowerDown, syncOutEnable, clkOutPhase, clkOutEnable}))
    else $error("settings changed with no frame");
endmodule
bind osc_output_state_regs osc_output_state_regs_props osc_output_state_regs_props_i (
  .core_clk, .arst_n, .spiCsN, .sdioOe, .clkOutEnable, .clkOutAmp, .clkOutSwingMv,
  .clkOutPhase, .syncOutPowerDown, .syncOutEnable, .syncOutFormat, .syncOutAmp,
  .syncOutSwingMv, .syncOutBiasDisable);
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the output state configuration bank.
// Assumes the bank's serial frame contract; the bench acts as host.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import osc_pkg::*;
  typedef struct {logic [6:0] a; logic [7:0] w, r;} osc_row_s;
  logic core_clk = 0, arst_n = 0, spiSclk = 0, spiCsN = 1, hostSdio = 0;
  logic sdioOut, sdioOe;
  logic [7:0] clkOutEnable, clkOutFormat, syncOutPowerDown, syncOutEnable, syncOutSourceSel;
  logic [7:0] syncOutFormat, syncOutBiasDisable, rd;
  osc_amp_t clkOutAmp, syncOutAmp;
  osc_mv_t clkOutSwingMv, syncOutSwingMv;
  osc_phase_t clkOutPhase;
  osc_dly_t syncOutDelay;
  int n_mismatch = 0, n_compared = 0;
  // Shared data wire: device wins while it drives
  wire logic sdioIn = sdioOe ? sdioOut : hostSdio;
  osc_row_s rows [11] = '{'{7'h28, 8'hff, 8'h1e}, '{7'h58, 8'h0e, 8'h0e},
    '{7'h2c, 8'hff, 8'hbc}, '{7'h5c, 8'h3c, 8'h3c}, '{7'h76, 8'hff, 8'hff},
    '{7'h60, 8'hff, 8'h1d}, '{7'h67, 8'h1d, 8'h1d}, '{7'h70, 8'hff, 8'hff},
    '{7'h73, 8'ha5, 8'ha5}, '{7'h10, 8'hff, 8'h00}, '{7'h7f, 8'hff, 8'h00}};
  osc_output_state_regs osc_output_state_regs_i (.core_clk, .arst_n, .spiSclk, .spiCsN,
    .sdioIn, .sdioOut, .sdioOe, .clkOutEnable, .clkOutFormat, .clkOutAmp, .clkOutSwingMv,
    .clkOutPhase, .syncOutPowerDown, .syncOutEnable, .syncOutSourceSel, .syncOutDelay,
    .syncOutFormat, .syncOutAmp, .syncOutSwingMv, .syncOutBiasDisable);
  initial forever #12.5 core_clk = ~core_clk;
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Fewer than 16 pulses aborts the frame
  task automatic frame(logic rw, logic [6:0] a, logic [7:0] d, int n = 16);
    logic [15:0] f;
    f = {rw, a, d};
    spiCsN = 0;
    tick(4);
    for (int i = 15; i > 15 - n; i--) begin
      hostSdio = f[i];
      tick(4);
      if (i < 8) rd[i] = sdioOut;
      spiSclk = 1;
      tick(4);
      spiSclk = 0;
    end
    tick(4);
    spiCsN = 1;
    hostSdio = 0;
    tick(8);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    tick(2);
    arst_n = 1;
    tick(4);
    chk(syncOutSourceSel, 8'hff);
    chk({clkOutEnable, syncOutEnable, clkOutFormat, syncOutFormat}, 32'h0);
    chk(syncOutSwingMv[3], 10'h0fa);
    frame(1, 7'h28, 8'h00);
    chk(rd, 8'h10);
    foreach (rows[k]) begin
      frame(0, rows[k].a, rows[k].w);
      frame(1, rows[k].a, 8'h00);
      chk(rd, rows[k].r);
    end
    chk(syncOutSourceSel, 8'h7f);
    chk({syncOutDelay[7], syncOutDelay[0]}, 6'h3f);
    chk({syncOutPowerDown, syncOutEnable}, 16'h01fe);
    chk({syncOutSwingMv[0], syncOutSwingMv[7]}, {10'h0, 10'h3e8});
    chk({syncOutFormat, syncOutBiasDisable}, 16'h8080);
    chk({clkOutEnable, clkOutFormat}, 16'h8181);
    chk(clkOutSwingMv[7], 10'h3e8);
    chk({clkOutPhase[3], clkOutPhase[0]}, 16'ha5ff);
    for (int c = 0; c < 4; c++) begin
      frame(0, 7'h3d, 8'(c << 2));
      chk({syncOutAmp[4], syncOutSwingMv[4]}, {2'(c), 10'((c + 1) * 250)});
    end
    frame(0, 7'h73, 8'h00, 10);
    chk(clkOutPhase[3], 8'ha5);
    frame(0, 7'h60, 8'h00);
    chk(clkOutEnable, 8'h80);
    frame(0, 7'h76, 8'hfe);
    chk(syncOutEnable, 8'h7e);
    arst_n = 0;
    tick(1);
    chk(clkOutPhase, 32'h0);
    chk(syncOutSourceSel, 8'hff);
    arst_n = 1;
    tick(4);
    frame(1, 7'h76, 8'h00);
    chk(rd, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
